// [src/smr_pkg.sv]
// Package for the sleep mode and reset control block.
// Assumes one system clock; no register bus, all controls are ports.
package smr_pkg;
    localparam int PORT_W = 8;
    localparam int MODE_W = 3;
    // Sleep mode select codes
    localparam logic [2:0] SEL_IDLE = 3'h0;
    localparam logic [2:0] SEL_NOISE = 3'h1;
    localparam logic [2:0] SEL_PDOWN = 3'h2;
    localparam logic [2:0] SEL_PSAVE = 3'h3;
    localparam logic [2:0] SEL_STBY = 3'h6;
    localparam logic [2:0] SEL_XSTBY = 3'h7;
    // Minimum external reset pulse, in ns, and its cycle count
    localparam int RST_MIN_NS = 2500;
    localparam int CLK_NS = 40;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CNT_W = 7;
    // Clock enable vector bit positions
    localparam int EN_CPU = 0;
    localparam int EN_SRAM = 1;
    localparam int EN_TMR = 2;
    localparam int EN_SER = 3;
    localparam int EN_IRQ = 4;
    localparam int EN_ATMR = 5;
    localparam int EN_ADC = 6;
    localparam int EN_OSC = 7;
    localparam int EN_W = 8;
    localparam logic [7:0] EN_ALL = 8'hff;
    localparam logic [7:0] EN_NONE = 8'h00;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b100
    } smr_state_t;
endpackage : smr_pkg

// [src/smr_port.sv]
// One 8-bit bidirectional port with per-bit pull-ups.
// Assumes reset force arrives asynchronously and is gated combinationally.
`timescale 1ns/1ns
module smr_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic force_hiz,
    input wire logic wr_en,
    input wire logic [7:0] wr_out,
    input wire logic [7:0] wr_dir,
    input wire logic [7:0] wr_pull,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pu,
    output logic [7:0] rd_pin
);
    logic [7:0] out_reg;
    logic [7:0] dir_reg;
    logic [7:0] pull_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_reg <= 8'h00;
            dir_reg <= 8'h00;
            pull_reg <= 8'h00;
        end else if (ce && wr_en) begin
            out_reg <= wr_out;
            dir_reg <= wr_dir;
            pull_reg <= wr_pull;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_pin <= 8'h00;
        end else if (ce) begin
            rd_pin <= pin_in;
        end
    end

    // Tri-state without any clock while reset stands
    assign pin_oe = force_hiz ? 8'h00 : dir_reg; // RULE_09
    assign pin_out = force_hiz ? 8'h00 : out_reg;
    // Pull-up only on input bits
    assign pin_pu = force_hiz ? 8'h00 : (pull_reg & ~dir_reg); // RULE_10
endmodule : smr_port

// [src/smr_rstfilt.sv]
// External reset pulse qualifier.
// Assumes the active-low reset pin is synchronous to the system clock.
`timescale 1ns/1ns
module smr_rstfilt (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic ext_rst_n,
    output logic ext_rst_hold
);
    logic [smr_pkg::RST_CNT_W-1:0] cnt_reg;

    // Held low long enough asserts a reset that lasts while pin is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (ce) begin
            if (ext_rst_n) begin
                cnt_reg <= '0;
            end else if (cnt_reg !=
                    smr_pkg::RST_CNT_W'(smr_pkg::RST_MIN_CYC)) begin
                cnt_reg <= cnt_reg + 1'b1; // RULE_08
            end
        end
    end

    assign ext_rst_hold = !ext_rst_n && (cnt_reg ==
        smr_pkg::RST_CNT_W'(smr_pkg::RST_MIN_CYC)); // RULE_08
endmodule : smr_rstfilt

// [src/smr_top.sv]
// Sleep mode and reset control: six sleep modes gate the domain clocks,
// external reset qualification, and four 8-bit ports that float in reset.
// Assumes SYS_RST is the power-on reset and pins are synchronous.
// Overview of operation
// RULE_01: Software picks one of six sleep modes through a mode select.
// RULE_02: Idle stops the processor; SRAM, timers, serial and irq run.
// RULE_03: Power-down stops the oscillator and all else until irq or reset; the code keeps irq running.
// RULE_04: Power-save is power-down with the asynchronous timer running.
// RULE_05: Noise reduction runs only the asynchronous timer and the ADC; the code also keeps the oscillator and irq running.
// RULE_06: Standby keeps only the main oscillator running; the code also keeps irq running.
// RULE_07: Extended standby keeps main oscillator and async timer running.
// RULE_08: An external reset held low past the minimum width resets all; the code keeps the port registers.
// RULE_09: Reset floats every pin of the four ports without a clock.
// RULE_10: Each port is 8-bit bidirectional with per-bit pull-ups.
// RULE_11: Sleep starts only on the sleep operation; irq or reset wakes.
`timescale 1ns/1ns
module smr_top (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic EXT_RST_N,
    input wire logic SLEEP_EN,
    input wire logic [2:0] SLEEP_MODE,
    input wire logic SLEEP_CMD,
    input wire logic WAKE_IRQ,
    input wire logic [3:0] PORT_WR,
    input wire logic [31:0] PORT_OUT_DATA,
    input wire logic [31:0] PORT_DIR_DATA,
    input wire logic [31:0] PORT_PULL_DATA,
    input wire logic [7:0] FIRST_PORT_PINS_IN,
    output logic [7:0] FIRST_PORT_PINS_OUT,
    output logic [7:0] FIRST_PORT_PINS_OE,
    output logic [7:0] FIRST_PORT_PINS_PU,
    input wire logic [7:0] SECOND_PORT_PINS_IN,
    output logic [7:0] SECOND_PORT_PINS_OUT,
    output logic [7:0] SECOND_PORT_PINS_OE,
    output logic [7:0] SECOND_PORT_PINS_PU,
    input wire logic [7:0] THIRD_PORT_PINS_IN,
    output logic [7:0] THIRD_PORT_PINS_OUT,
    output logic [7:0] THIRD_PORT_PINS_OE,
    output logic [7:0] THIRD_PORT_PINS_PU,
    input wire logic [7:0] FOURTH_PORT_PINS_IN,
    output logic [7:0] FOURTH_PORT_PINS_OUT,
    output logic [7:0] FOURTH_PORT_PINS_OE,
    output logic [7:0] FOURTH_PORT_PINS_PU,
    output logic [31:0] PORT_PIN_DATA,
    output logic [7:0] DOMAIN_EN,
    output logic SLEEPING,
    output logic MODE_BAD,
    output logic RESET_OUT
);
    smr_pkg::smr_state_t state_reg;
    smr_pkg::smr_state_t state_next;
    logic [2:0] mode_reg;
    logic [7:0] en_reg;
    logic [7:0] en_next;
    logic ext_hold;
    logic chip_rst;
    logic [7:0] pins_in [4];
    logic [7:0] pins_out [4];
    logic [7:0] pins_oe [4];
    logic [7:0] pins_pu [4];
    logic [7:0] pins_rd [4];

    // Domains kept running for each sleep mode
    function automatic logic [7:0] mode_enables(input logic [2:0] m);
        logic [7:0] e;
        e = smr_pkg::EN_NONE;
        unique case (m)
            smr_pkg::SEL_IDLE: begin
                e = smr_pkg::EN_ALL; // RULE_02
                e[smr_pkg::EN_CPU] = 1'b0;
                e[smr_pkg::EN_ADC] = 1'b0;
            end
            smr_pkg::SEL_NOISE: begin
                e[smr_pkg::EN_ATMR] = 1'b1; // RULE_05
                e[smr_pkg::EN_ADC] = 1'b1;
                e[smr_pkg::EN_OSC] = 1'b1;
                e[smr_pkg::EN_IRQ] = 1'b1;
            end
            smr_pkg::SEL_PDOWN: begin
                e[smr_pkg::EN_IRQ] = 1'b1; // RULE_03
            end
            smr_pkg::SEL_PSAVE: begin
                e[smr_pkg::EN_IRQ] = 1'b1; // RULE_04
                e[smr_pkg::EN_ATMR] = 1'b1;
            end
            smr_pkg::SEL_STBY: begin
                e[smr_pkg::EN_IRQ] = 1'b1; // RULE_06
                e[smr_pkg::EN_OSC] = 1'b1;
            end
            smr_pkg::SEL_XSTBY: begin
                e[smr_pkg::EN_IRQ] = 1'b1; // RULE_07
                e[smr_pkg::EN_OSC] = 1'b1;
                e[smr_pkg::EN_ATMR] = 1'b1;
            end
            default: begin
                e = smr_pkg::EN_ALL;
            end
        endcase
        return e;
    endfunction : mode_enables

    function automatic logic mode_legal(input logic [2:0] m);
        return (m == smr_pkg::SEL_IDLE) || (m == smr_pkg::SEL_NOISE) ||
            (m == smr_pkg::SEL_PDOWN) || (m == smr_pkg::SEL_PSAVE) ||
            (m == smr_pkg::SEL_STBY) || (m == smr_pkg::SEL_XSTBY);
    endfunction : mode_legal

    smr_rstfilt u_rstfilt (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .ext_rst_n(EXT_RST_N),
        .ext_rst_hold(ext_hold)
    );

    assign chip_rst = SYS_RST | ext_hold; // RULE_08
    assign RESET_OUT = chip_rst;

    // Sleep sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            smr_pkg::ST_RUN: begin
                if (SLEEP_CMD && SLEEP_EN && mode_legal(SLEEP_MODE)) begin
                    state_next = smr_pkg::ST_SLEEP; // RULE_11
                end
            end
            smr_pkg::ST_SLEEP: begin
                if (WAKE_IRQ) begin
                    state_next = smr_pkg::ST_WAKE; // RULE_11
                end
            end
            smr_pkg::ST_WAKE: begin
                state_next = smr_pkg::ST_RUN;
            end
            default: begin
                state_next = smr_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= smr_pkg::ST_RUN;
        end else if (CLK_EN) begin
            if (ext_hold) begin
                state_reg <= smr_pkg::ST_RUN; // RULE_03
            end else begin
                state_reg <= state_next;
            end
        end
    end

    // Mode latched when sleep is entered
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode_reg <= smr_pkg::SEL_IDLE;
        end else if (CLK_EN && state_reg == smr_pkg::ST_RUN) begin
            mode_reg <= SLEEP_MODE; // RULE_01
        end
    end

    always_comb begin
        if (state_next == smr_pkg::ST_SLEEP && !ext_hold) begin
            en_next = mode_enables(state_reg == smr_pkg::ST_SLEEP ?
                mode_reg : SLEEP_MODE);
        end else begin
            en_next = smr_pkg::EN_ALL;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            en_reg <= smr_pkg::EN_ALL;
        end else if (CLK_EN) begin
            en_reg <= en_next; // RULE_01
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            MODE_BAD <= 1'b0;
        end else if (CLK_EN) begin
            MODE_BAD <= SLEEP_CMD && SLEEP_EN && !mode_legal(SLEEP_MODE);
        end
    end

    assign DOMAIN_EN = en_reg;
    assign SLEEPING = (state_reg == smr_pkg::ST_SLEEP);

    assign pins_in[0] = FIRST_PORT_PINS_IN;
    assign pins_in[1] = SECOND_PORT_PINS_IN;
    assign pins_in[2] = THIRD_PORT_PINS_IN;
    assign pins_in[3] = FOURTH_PORT_PINS_IN;

    for (genvar i = 0; i < 4; i++) begin : g_port
        smr_port u_port (
            .clk(CLK_SYS),
            .rst(SYS_RST),
            .ce(CLK_EN),
            .force_hiz(chip_rst), // RULE_09
            .wr_en(PORT_WR[i] && !ext_hold),
            .wr_out(PORT_OUT_DATA[i*8 +: 8]),
            .wr_dir(PORT_DIR_DATA[i*8 +: 8]),
            .wr_pull(PORT_PULL_DATA[i*8 +: 8]),
            .pin_in(pins_in[i]),
            .pin_out(pins_out[i]),
            .pin_oe(pins_oe[i]),
            .pin_pu(pins_pu[i]),
            .rd_pin(pins_rd[i])
        );
        assign PORT_PIN_DATA[i*8 +: 8] = pins_rd[i]; // RULE_10
    end

    assign FIRST_PORT_PINS_OUT = pins_out[0];
    assign FIRST_PORT_PINS_OE = pins_oe[0];
    assign FIRST_PORT_PINS_PU = pins_pu[0];
    assign SECOND_PORT_PINS_OUT = pins_out[1];
    assign SECOND_PORT_PINS_OE = pins_oe[1];
    assign SECOND_PORT_PINS_PU = pins_pu[1];
    assign THIRD_PORT_PINS_OUT = pins_out[2];
    assign THIRD_PORT_PINS_OE = pins_oe[2];
    assign THIRD_PORT_PINS_PU = pins_pu[2];
    assign FOURTH_PORT_PINS_OUT = pins_out[3];
    assign FOURTH_PORT_PINS_OE = pins_oe[3];
    assign FOURTH_PORT_PINS_PU = pins_pu[3];
endmodule : smr_top

// [tb/smr_top_asserts.sv]
// Checker for the sleep mode and reset control top level.
// Bound to smr_top; sees only its ports.
`timescale 1ns/1ns
module smr_chk (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic EXT_RST_N,
    input wire logic SLEEP_EN,
    input wire logic [2:0] SLEEP_MODE,
    input wire logic SLEEP_CMD,
    input wire logic WAKE_IRQ,
    input wire logic [3:0] PORT_WR,
    input wire logic [31:0] PORT_DIR_DATA,
    input wire logic [31:0] PORT_PULL_DATA,
    input wire logic [7:0] FIRST_PORT_PINS_OE,
    input wire logic [7:0] FIRST_PORT_PINS_PU,
    input wire logic [7:0] FOURTH_PORT_PINS_OE,
    input wire logic [7:0] DOMAIN_EN,
    input wire logic SLEEPING,
    input wire logic MODE_BAD,
    input wire logic RESET_OUT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    logic [7:0] mk [8] = '{8'hbe, 8'hf0, 8'h10, 8'h30, 8'h00, 8'h00, 8'h90,
        8'hb0};
    logic [6:0] lo_cnt;
    logic go;
    logic ok;
    logic [7:0] d0;
    assign d0 = PORT_DIR_DATA[7:0];
    assign ok = SLEEP_MODE[2:1] != 2'b10;
    assign go = CLK_EN && SLEEP_CMD && SLEEP_EN && !SLEEPING && !RESET_OUT;
    // Enabled edges with the external reset pin low
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST)
            lo_cnt <= 7'h00;
        else if (CLK_EN && EXT_RST_N)
            lo_cnt <= 7'h00;
        else if (CLK_EN && lo_cnt != 7'h7f)
            lo_cnt <= lo_cnt + 7'h01;
    end
    sequence s_go;
        go && ok;
    endsequence
    property p_msk_lo;
        s_go ##0 !SLEEP_MODE[2] |=> DOMAIN_EN == mk[$past(SLEEP_MODE)];
    endproperty
    property p_msk_hi;
        s_go ##0 SLEEP_MODE[2] |=> DOMAIN_EN == mk[$past(SLEEP_MODE)];
    endproperty
    property p_enter;
        s_go |=> SLEEPING;
    endproperty
    property p_hold;
        !SLEEPING && !(CLK_EN && SLEEP_CMD) |=> !SLEEPING;
    endproperty
    property p_wake;
        SLEEPING && WAKE_IRQ && CLK_EN |=> !SLEEPING && DOMAIN_EN == 8'hff;
    endproperty
    property p_stay;
        SLEEPING && !WAKE_IRQ && EXT_RST_N && !RESET_OUT
            |=> SLEEPING && $stable(DOMAIN_EN);
    endproperty
    property p_bad;
        go && !ok |=> MODE_BAD && !SLEEPING;
    endproperty
    property p_hiz;
        RESET_OUT |-> (FIRST_PORT_PINS_OE | FOURTH_PORT_PINS_OE
            | FIRST_PORT_PINS_PU) == 8'h00;
    endproperty
    property p_ext;
        int'(lo_cnt) >= smr_pkg::RST_MIN_CYC && !EXT_RST_N |-> RESET_OUT;
    endproperty
    property p_short;
        lo_cnt != 0 && int'(lo_cnt) < smr_pkg::RST_MIN_CYC |-> !RESET_OUT;
    endproperty
    property p_wr;
        CLK_EN && PORT_WR[0] && !RESET_OUT |=> RESET_OUT
            || (FIRST_PORT_PINS_OE == $past(d0) && FIRST_PORT_PINS_PU
            == ($past(PORT_PULL_DATA[7:0]) & ~$past(d0)));
    endproperty
    a_msk_lo: assert property (p_msk_lo)
        else $error("domain mask wrong");
    a_msk_hi: assert property (p_msk_hi)
        else $error("domain mask wrong");
    a_enter: assert property (p_enter)
        else $error("sleep not entered");
    a_hold: assert property (p_hold)
        else $error("sleep without command");
    a_wake: assert property (p_wake)
        else $error("no wake on irq");
    a_stay: assert property (p_stay)
        else $error("left sleep early");
    a_bad: assert property (p_bad)
        else $error("illegal code not refused");
    a_hiz: assert property (p_hiz)
        else $error("pins driven in reset");
    a_ext: assert property (p_ext)
        else $error("long pulse gave no reset");
    a_short: assert property (p_short)
        else $error("reset before minimum width");
    a_wr: assert property (p_wr)
        else $error("port write lost");
endmodule : smr_chk
bind smr_top smr_chk u_chk (.*);

// [tb/tb_sleep_mode_and_reset_control.sv]
// Self-checking bench for smr_top: sleep modes, ports, resets.
// Drives all inputs 1 ns after each rising edge.
`timescale 1ns/1ns
module tb_sleep_mode_and_reset_control;
    logic CLK_SYS, SYS_RST, CLK_EN, EXT_RST_N, SLEEP_EN, SLEEP_CMD, WAKE_IRQ;
    logic SLEEPING, MODE_BAD, RESET_OUT;
    logic [2:0] SLEEP_MODE;
    logic [3:0] PORT_WR;
    logic [7:0] DOMAIN_EN;
    logic [31:0] PORT_OUT_DATA, PORT_DIR_DATA, PORT_PULL_DATA, PORT_PIN_DATA;
    logic [7:0] FIRST_PORT_PINS_IN, FIRST_PORT_PINS_OUT, FIRST_PORT_PINS_OE;
    logic [7:0] SECOND_PORT_PINS_IN, SECOND_PORT_PINS_OUT, SECOND_PORT_PINS_OE;
    logic [7:0] THIRD_PORT_PINS_IN, THIRD_PORT_PINS_OUT, THIRD_PORT_PINS_OE;
    logic [7:0] FOURTH_PORT_PINS_IN, FOURTH_PORT_PINS_OUT, FOURTH_PORT_PINS_OE;
    logic [7:0] FIRST_PORT_PINS_PU, SECOND_PORT_PINS_PU;
    logic [7:0] THIRD_PORT_PINS_PU, FOURTH_PORT_PINS_PU;
    logic [31:0] pin_in, dir, pull, oe, pu, po;
    logic [7:0] mk [8] = '{8'hbe, 8'hf0, 8'h10, 8'h30, 8'h00, 8'h00, 8'h90,
        8'hb0};
    integer seed = 32'h2cde;
    int n_fail = 0;
    int num_checks = 0;
    assign {FOURTH_PORT_PINS_IN, THIRD_PORT_PINS_IN, SECOND_PORT_PINS_IN,
        FIRST_PORT_PINS_IN} = pin_in;
    assign oe = {FOURTH_PORT_PINS_OE, THIRD_PORT_PINS_OE,
        SECOND_PORT_PINS_OE, FIRST_PORT_PINS_OE};
    assign pu = {FOURTH_PORT_PINS_PU, THIRD_PORT_PINS_PU,
        SECOND_PORT_PINS_PU, FIRST_PORT_PINS_PU};
    assign po = {FOURTH_PORT_PINS_OUT, THIRD_PORT_PINS_OUT,
        SECOND_PORT_PINS_OUT, FIRST_PORT_PINS_OUT};
    smr_top dut (.*);
    initial begin
        CLK_SYS = 0;
        forever #20 CLK_SYS = ~CLK_SYS;
    end
    function automatic logic [31:0] pux(input logic [31:0] d, p);
        return p & ~d;
    endfunction : pux
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [31:0] d, p);
        PORT_DIR_DATA = d;
        PORT_PULL_DATA = p;
        PORT_OUT_DATA = $random(seed);
        PORT_WR = 4'hf;
        tick(1);
        PORT_WR = 4'h0;
    endtask : wr
    initial begin
        tick(20000);
        n_fail++;
        finish_test;
    end
    initial begin
        {SYS_RST, CLK_EN, EXT_RST_N, SLEEP_EN} = 4'hf;
        {SLEEP_CMD, WAKE_IRQ, SLEEP_MODE, PORT_WR} = 0;
        {PORT_OUT_DATA, PORT_DIR_DATA, PORT_PULL_DATA, pin_in} = 0;
        tick(3);
        chk(DOMAIN_EN, 8'hff);
        chk(oe, 0);
        SYS_RST = 0;
        for (int i = 0; i < 10; i++) begin
            dir = i == 0 ? 32'h0 : $random(seed);
            pull = i < 2 ? 32'hffffffff : $random(seed);
            pin_in = $random(seed);
            wr(dir, pull);
            chk(oe, dir);
            chk(pu, pux(dir, pull));
            chk(PORT_PIN_DATA, pin_in);
            chk(po, PORT_OUT_DATA);
            tick(1);
        end
        for (int m = 0; m < 8; m++) begin
            SLEEP_MODE = m[2:0];
            SLEEP_CMD = 1;
            tick(1);
            chk(MODE_BAD, m == 4 || m == 5);
            chk(SLEEPING, m != 4 && m != 5);
            // Command held on while asleep must be ignored
            if (m != 4 && m != 5) begin
                chk(DOMAIN_EN, mk[m]);
                tick(3);
            end
            SLEEP_CMD = 0;
            if (m != 4 && m != 5) begin
                chk(SLEEPING, 1);
                chk(MODE_BAD, 0);
                chk(DOMAIN_EN, mk[m]);
                WAKE_IRQ = 1;
                tick(1);
                WAKE_IRQ = 0;
                chk(SLEEPING, 0);
                chk(DOMAIN_EN, 8'hff);
            end
            tick(1);
        end
        SLEEP_EN = 0;
        SLEEP_CMD = 1;
        tick(1);
        chk(SLEEPING, 0);
        SLEEP_EN = 1;
        CLK_EN = 0;
        tick(1);
        chk(SLEEPING, 0);
        CLK_EN = 1;
        SLEEP_CMD = 0;
        EXT_RST_N = 0;
        tick(smr_pkg::RST_MIN_CYC - 1);
        chk(RESET_OUT, 0);
        tick(1);
        chk(RESET_OUT, 1);
        chk(oe | pu, 0);
        chk(po, 0);
        wr(32'h0, 32'h0);
        EXT_RST_N = 1;
        tick(2);
        chk(RESET_OUT, 0);
        chk(oe, dir);
        SLEEP_MODE = 3'h2;
        SLEEP_CMD = 1;
        tick(1);
        SLEEP_CMD = 0;
        chk(SLEEPING, 1);
        chk(DOMAIN_EN, mk[2]);
        SYS_RST = 1;
        #5;
        chk(oe, 0);
        chk(po | pu, 0);
        chk(RESET_OUT, 1);
        tick(3);
        SYS_RST = 0;
        chk(SLEEPING, 0);
        chk(DOMAIN_EN, 8'hff);
        tick(2);
        chk(SLEEPING, 0);
        chk(RESET_OUT, 0);
        chk(oe, 0);
        finish_test;
    end
endmodule : tb_sleep_mode_and_reset_control
